// ---- common/adp_defines.svh ----
// adp_defines.svh: constants of the ddr sample output port
// How it works
// - capture a new sample each sampling-clock rise
// - pipeline steps on both sampling-clock edges
// - result appears 3.5 sampling-clock cycles later
// - result is 12-bit offset binary code
// - bit 11 is msb, bit 0 is lsb
// - over-range flag high at either full-scale code
// - strobe toggles together with data and flag
// - new word on each strobe edge, ddr
// - strobe, data and flag change at clock fall
`ifndef ADP_DEFINES_SVH
`define ADP_DEFINES_SVH

// ****************************************************************
// widths and codes
// ****************************************************************
`define ADP_CODE_W 12
`define ADP_IN_W 16
`define ADP_MID_CODE 12'h800
`define ADP_MIN_CODE 12'h000
`define ADP_MAX_CODE 12'hfff
`define ADP_IN_MIN 16'hf800
`define ADP_IN_MAX 16'h07ff

// ****************************************************************
// pipeline and timing
// ****************************************************************
`define ADP_MEM_DEPTH 6
`define ADP_LATENCY_HALF_STEPS 7
`define ADP_REF_PERIOD_NS 25
`define ADP_RST_STROBE 1'b0
`define ADP_RST_CODE 12'h800

`endif

// ---- common/adp_pkg.sv ----
// adp_pkg.sv: types and encoder of the ddr sample output port
`default_nettype none
`include "adp_defines.svh"

package adp_pkg;

	// ****************************************************************
	// carried word and module states
	// ****************************************************************
	typedef struct packed
	{
		logic over_range;
		logic [`ADP_CODE_W-1:0] code;
	} adp_word_t;

	typedef struct packed
	{
		adp_word_t [`ADP_MEM_DEPTH-1:0] stage;
		adp_word_t rd;
	} adp_mem_state_t;

	typedef struct packed
	{
		logic clk_meta;
		logic clk_sync;
		logic clk_prev;
		logic [`ADP_IN_W-1:0] ain_meta;
		logic [`ADP_IN_W-1:0] ain_sync;
		adp_word_t out_word;
		logic strobe;
	} adp_port_state_t;

	// clamp a signed input level and map it to offset binary
	function automatic adp_word_t adp_encode(input logic [`ADP_IN_W-1:0] ain);
		adp_word_t w;
		w.over_range = 1'b0;
		w.code = ain[`ADP_CODE_W-1:0] ^ `ADP_MID_CODE;
		if ($signed(ain) <= $signed(`ADP_IN_MIN))
		begin
			w.code = `ADP_MIN_CODE;
			w.over_range = 1'b1;
		end
		else if ($signed(ain) >= $signed(`ADP_IN_MAX))
		begin
			w.code = `ADP_MAX_CODE;
			w.over_range = 1'b1;
		end
		return w;
	endfunction

endpackage : adp_pkg

`default_nettype wire

// ---- src/adp_stage_mem.sv ----
// adp_stage_mem.sv: half-step pipeline store with registered read word
`default_nettype none
`include "adp_defines.svh"

module adp_stage_mem
(
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// stepping
	input wire logic shift,
	input wire logic wr,
	// words
	input wire adp_pkg::adp_word_t din,
	output adp_pkg::adp_word_t dout
);
	import adp_pkg::*;

	adp_mem_state_t st;
	adp_mem_state_t next_st;

	// ****************************************************************
	// shift on every clock edge event
	// ****************************************************************
	// head takes the new sample when wr is high, else holds; every later stage moves one step
	always_comb
	begin
		next_st = st;
		if (shift)
		begin
			next_st.stage[0] = wr ? din : st.stage[0];
			for (int i = 1; i < `ADP_MEM_DEPTH; i++)
			begin
				next_st.stage[i] = st.stage[i-1];
			end
			next_st.rd = st.stage[`ADP_MEM_DEPTH-1];
		end
		// bubbles carry mid code with flag low, never a false full scale
		if (srst)
		begin
			next_st = '0;
			for (int i = 0; i < `ADP_MEM_DEPTH; i++)
			begin
				next_st.stage[i].code = `ADP_RST_CODE;
			end
			next_st.rd.code = `ADP_RST_CODE;
		end
	end

	// state register
	always_ff @(posedge clk)
	begin
		st <= next_st;
	end

	assign dout = st.rd; // straight from the read register

	// ****************************************************************
	// checks
	// ****************************************************************
	a_tail_step: assert property (@(posedge clk) disable iff (srst)
		shift |=> dout == $past(st.stage[`ADP_MEM_DEPTH-1]))
		else $error("read word did not take the tail stage");

	a_hold_still: assert property (@(posedge clk) disable iff (srst)
		(!shift && !$past(srst)) |=> $stable(dout))
		else $error("read word moved without a clock edge");

endmodule // adp_stage_mem

`default_nettype wire

// ---- src/adp_sample_port.sv ----
// adp_sample_port.sv: converter digital side driving the ddr output link
`default_nettype none
`include "adp_defines.svh"

module adp_sample_port
(
	// clock and reset
	input wire logic REF_CLK,
	input wire logic SRST,
	// sampling side, asynchronous to REF_CLK
	input wire logic SAMPLE_CLK,
	input wire logic [`ADP_IN_W-1:0] ANALOG_IN,
	// ddr link out
	output logic [`ADP_CODE_W-1:0] SAMPLE_BITS,
	output logic OVER_RANGE_FLAG,
	output logic SAMPLE_STROBE_OUT
);
	import adp_pkg::*;

	adp_port_state_t st;
	adp_port_state_t next_st;
	logic rise;
	logic fall;
	logic shift;
	adp_word_t head_din;
	adp_word_t mem_dout;

	// ****************************************************************
	// sampling clock edges
	// ****************************************************************
	// edges seen on the synchronised level only
	assign rise = st.clk_sync & ~st.clk_prev;
	assign fall = ~st.clk_sync & st.clk_prev;
	assign shift = rise | fall;
	assign head_din = adp_encode(st.ain_sync);

	// ****************************************************************
	// pipeline store
	// ****************************************************************
	adp_stage_mem u_mem
	(
		.clk(REF_CLK),
		.srst(SRST),
		.shift(shift),
		.wr(rise),
		.din(head_din),
		.dout(mem_dout)
	);

	// ****************************************************************
	// next state
	// ****************************************************************
	// synchronisers, then output update on the clock fall
	always_comb
	begin
		next_st = st;
		next_st.clk_meta = SAMPLE_CLK;
		next_st.clk_sync = st.clk_meta;
		next_st.clk_prev = st.clk_sync;
		next_st.ain_meta = ANALOG_IN;
		next_st.ain_sync = st.ain_meta;
		if (fall)
		begin
			next_st.out_word = mem_dout;
			next_st.strobe = ~st.strobe;
		end
		if (SRST)
		begin
			next_st = '0;
			next_st.strobe = `ADP_RST_STROBE;
			next_st.out_word.code = `ADP_RST_CODE;
			// chain keeps tracking the pin, so release gives no false edge
			next_st.clk_meta = SAMPLE_CLK;
			next_st.clk_sync = st.clk_meta;
			next_st.clk_prev = st.clk_sync;
		end
	end

	// state register
	always_ff @(posedge REF_CLK)
	begin
		st <= next_st;
	end

	// outputs straight from the state register
	assign SAMPLE_BITS = st.out_word.code;
	assign OVER_RANGE_FLAG = st.out_word.over_range;
	assign SAMPLE_STROBE_OUT = st.strobe;

	// ****************************************************************
	// checks
	// ****************************************************************
	a_latency_word: assert property (@(posedge REF_CLK) disable iff (SRST)
		rise |-> ##29 ({OVER_RANGE_FLAG, SAMPLE_BITS} == $past(head_din, 29)))
		else $error("sample did not appear 3.5 clock cycles later");

	a_capture_rise: assert property (@(posedge REF_CLK) disable iff (SRST)
		rise |=> (u_mem.st.stage[0] == $past(head_din)))
		else $error("rising edge did not capture a sample");

	a_zero_mid: assert property (@(posedge REF_CLK) disable iff (SRST)
		(rise && st.ain_sync == 16'h0000) |-> ##29 SAMPLE_BITS == `ADP_MID_CODE)
		else $error("zero input did not give mid code");

	a_msb_sign: assert property (@(posedge REF_CLK) disable iff (SRST)
		rise |-> ##29 (SAMPLE_BITS[`ADP_CODE_W-1] == !$past(st.ain_sync[15], 29)))
		else $error("msb does not follow input sign");

	a_range_flag: assert property (@(posedge REF_CLK) disable iff (SRST)
		$past(fall) |-> OVER_RANGE_FLAG ==
		(SAMPLE_BITS == `ADP_MIN_CODE || SAMPLE_BITS == `ADP_MAX_CODE))
		else $error("over-range flag disagrees with full-scale code");

	a_strobe_with: assert property (@(posedge REF_CLK) disable iff (SRST)
		($changed(SAMPLE_BITS) || $changed(OVER_RANGE_FLAG)) |->
		$changed(SAMPLE_STROBE_OUT))
		else $error("data changed without a strobe edge");

	a_ddr_toggle: assert property (@(posedge REF_CLK) disable iff (SRST)
		fall |=> SAMPLE_STROBE_OUT != $past(SAMPLE_STROBE_OUT))
		else $error("strobe missed a toggle on clock fall");

	a_fall_only: assert property (@(posedge REF_CLK) disable iff (SRST)
		$changed(SAMPLE_STROBE_OUT) |-> $past(fall) && !$past(rise))
		else $error("strobe moved away from a clock fall");

endmodule // adp_sample_port

`default_nettype wire

// ---- verif/adp_capture_model.sv ----
// adp_capture_model.sv: receiver that keeps one word per strobe edge
`default_nettype none

module adp_capture_model
(
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// ddr link in
	input wire logic [11:0] bits,
	input wire logic flag,
	input wire logic strobe,
	// captured words
	output adp_pkg::adp_word_t word,
	output logic valid,
	output logic rise
);
	timeunit 1ns;
	timeprecision 100ps;
	import adp_pkg::*;

	logic last;

	// ****
	// capture on both strobe edges
	// ****
	always_ff @(posedge clk)
	begin
		last <= strobe;
		valid <= 1'b0;
		if (srst)
			last <= 1'b0;
		else if (strobe != last)
		begin
			word <= '{flag, bits};
			valid <= 1'b1;
			rise <= strobe;
		end
	end
endmodule // adp_capture_model

`default_nettype wire

// ---- verif/adp_ddr_sample_output_port_tb.sv ----
// adp_ddr_sample_output_port_tb.sv: self-checking bench of the sample port
`default_nettype none
`include "adp_defines.svh"

module adp_ddr_sample_output_port_tb;
	timeunit 1ns;
	timeprecision 100ps;
	import adp_pkg::*;

	logic ref_clk = 1'b0;
	logic srst = 1'b1;
	logic sample_clk = 1'b0;
	logic [15:0] analog_in = 16'h0000;
	logic [11:0] bits;
	logic flag, strobe, valid, rise;
	adp_word_t word;
	int err_count = 0;
	int checks = 0;

	adp_sample_port i_dut (.REF_CLK(ref_clk), .SRST(srst),
		.SAMPLE_CLK(sample_clk), .ANALOG_IN(analog_in),
		.SAMPLE_BITS(bits), .OVER_RANGE_FLAG(flag),
		.SAMPLE_STROBE_OUT(strobe));
	adp_capture_model i_rx (.clk(ref_clk), .srst(srst), .bits(bits),
		.flag(flag), .strobe(strobe), .word(word), .valid(valid),
		.rise(rise));

	// ****
	// clocks, the sampling clock unrelated in phase
	// ****
	initial forever #12.5 ref_clk = ~ref_clk;
	initial
	begin
		#7;
		forever #100 sample_clk = ~sample_clk;
	end

	task automatic final_report();
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic cmp_word(input string what, input adp_word_t exp,
		input adp_word_t got);
		checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic cmp_edge(input logic exp, input logic got);
		checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("FAIL strobe edge expected %b seen %b", exp, got);
		end
	endtask

	// bounded wait for the receiver's next word
	task automatic wait_word();
		for (int n = 0; n < 40; n++)
		begin
			@(negedge ref_clk);
			if (valid === 1'b1)
				return;
		end
		err_count++;
		$display("FAIL word wait expected 1 seen 0");
		final_report();
	endtask

	// drive four samples back to back, check one per fall from the 4th fall on
	task automatic stream(input logic [15:0] v[4], input adp_word_t e[4]);
		logic p;
		fork
			for (int i = 0; i < 4; i++)
			begin
				@(negedge sample_clk);
				@(posedge ref_clk);
				analog_in <= v[i];
			end
			begin
				@(negedge sample_clk);
				@(posedge sample_clk);
				repeat (3) wait_word();
				p = rise;
				for (int i = 0; i < 4; i++)
				begin
					wait_word();
					cmp_word("word", e[i], word);
					cmp_edge(~p, rise);
					p = rise;
				end
			end
		join
	endtask

	task automatic t_code();
		stream('{16'h0000, 16'hf801, 16'h07fe, 16'hffff},
			'{13'h0800, 13'h0001, 13'h0ffe, 13'h07ff});
		$display("test code done");
	endtask

	// mid-run reset: outputs at reset level during and after release
	task automatic t_reset();
		@(posedge ref_clk);
		srst <= 1'b1;
		repeat (10) @(posedge ref_clk);
		@(negedge ref_clk);
		cmp_word("reset word", {1'b0, `ADP_RST_CODE}, {flag, bits});
		cmp_edge(`ADP_RST_STROBE, strobe);
		@(posedge ref_clk);
		srst <= 1'b0;
		@(negedge ref_clk);
		cmp_word("release word", {1'b0, `ADP_RST_CODE}, {flag, bits});
		cmp_edge(`ADP_RST_STROBE, strobe);
		$display("test reset done");
	endtask

	task automatic t_range();
		stream('{16'h07ff, 16'hf800, 16'h7fff, 16'h8000},
			'{13'h1fff, 13'h1000, 13'h1fff, 13'h1000});
		$display("test range done");
	endtask

	initial
	begin
		repeat (10) @(posedge ref_clk);
		srst <= 1'b0;
		t_code();
		t_reset();
		t_range();
		final_report();
	end
endmodule // adp_ddr_sample_output_port_tb

`default_nettype wire
